// file: bench/sipo_feeder.sv
`timescale 1ns/1ns
// ----
// Upstream driver
// ----
module sipo_feeder (
  input  wire  clk,        // Clock
  output logic shiftClock, // Idle low
  output logic serialA,    // Data A
  output logic serialB     // Data B
);
  initial begin
    shiftClock = 1'b0;
    serialA = 1'b1;
    serialB = 1'b1;
  end
  // Five cycles each side so no level is missed
  task automatic shift(input logic a, input logic b);
    @(negedge clk);
    serialA = a;
    serialB = b;
    repeat (5) @(negedge clk);
    shiftClock = 1'b1;
    repeat (5) @(negedge clk);
    shiftClock = 1'b0;
  endtask
endmodule // sipo_feeder

// file: bench/sipo_shifter_chk.sv
`timescale 1ns/1ns
// ----
// Port checks
// ----
module sipo_chk (
  input wire       clk,          // Clock
  input wire       rst,          // Reset
  input wire       shiftClock,   // Shift pin
  input wire       clearN,       // Clear pin
  input wire       serialA,      // Data A
  input wire       serialB,      // Data B
  input wire [7:0] stageOutputs, // Stages
  input wire [7:0] wordData,     // Head word
  input wire       wordValid,    // Word waiting
  input wire       wordReady     // Word taken
);
  wire both = serialA & serialB;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence shifted; clearN && $changed(stageOutputs); endsequence
  // Eight quiet cycles outlast the synchroniser delay
  sequence quiet; (clearN && $stable(shiftClock))[*8]; endsequence
  AST_SHIFT: assert property (
    shifted |-> stageOutputs[7:1] == $past(stageOutputs[6:0])) else $error("no shift");
  AST_LOAD: assert property (
    shifted |-> stageOutputs[0] == $past(both, 5)) else $error("bad first stage");
  AST_GATE: assert property (
    shifted and $past(serialA, 5) |-> stageOutputs[0] == $past(serialB, 5)) else $error("gate");
  AST_CLEAR: assert property (
    !clearN |-> stageOutputs == 8'h00) else $error("clear ignored");
  AST_HOLD: assert property (
    quiet |-> $stable(stageOutputs)) else $error("stages moved");
  AST_OFFER: assert property (
    shifted and !wordValid |=> wordValid && wordData == $past(stageOutputs)) else $error("offer");
  AST_STAND: assert property (
    wordValid && !wordReady && clearN |=> !clearN || wordValid && $stable(wordData))
    else $error("word lost");
endmodule // sipo_chk

bind sipo_shifter sipo_chk sipo_chk_inst (.clk, .rst, .shiftClock, .clearN, .serialA,
  .serialB, .stageOutputs, .wordData, .wordValid, .wordReady);

// file: bench/sipo_shifter_tb_top.sv
`timescale 1ns/1ns
module sipo_shifter_tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       clearN = 1'b1;
  logic       wordReady = 1'b0;
  wire        shiftClock, serialA, serialB, wordValid;
  wire  [7:0] stageOutputs, wordData;
  int         n_mismatch = 0, n_compared = 0, cycles = 0;
  logic [9:0] rows [8] = '{10'h301, 10'h102, 10'h204, 10'h008, 10'h311, 10'h323, 10'h146, 10'h38D};
  always #25 clk = ~clk;
  sipo_feeder sipo_feeder_inst (.clk(clk), .shiftClock(shiftClock), .serialA(serialA),
    .serialB(serialB));
  sipo_shifter sipo_shifter_inst (.clk(clk), .rst(rst), .shiftClock(shiftClock),
    .clearN(clearN), .serialA(serialA), .serialB(serialB), .stageOutputs(stageOutputs),
    .wordData(wordData), .wordValid(wordValid), .wordReady(wordReady));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string name);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check(stageOutputs, 8'h00, "reset stages");
    check({7'h00, wordValid}, 8'h00, "reset valid");
    // Receiver stalls: two words kept, later ones dropped
    foreach (rows[i]) begin
      sipo_feeder_inst.shift(rows[i][9], rows[i][8]);
      repeat (8) @(negedge clk);
      check(stageOutputs, rows[i][7:0], "stages");
    end
    check(wordData, 8'h01, "head word");
    wordReady = 1'b1;
    @(negedge clk);
    check(wordData, 8'h02, "second word");
    @(negedge clk);
    wordReady = 1'b0;
    check({7'h00, wordValid}, 8'h00, "drained");
    clearN = 1'b0;
    #1 check(stageOutputs, 8'h00, "cleared");
    sipo_feeder_inst.shift(1'b1, 1'b1);
    repeat (8) @(negedge clk);
    check(stageOutputs, 8'h00, "clear wins");
    clearN = 1'b1;
    sipo_feeder_inst.shift(1'b1, 1'b1);
    repeat (8) @(negedge clk);
    sipo_feeder_inst.serialA = 1'b0;
    repeat (8) @(negedge clk);
    check(stageOutputs, 8'h01, "held");
    stop_test;
  end
endmodule // sipo_shifter_tb_top

// file: hdl/sipo_defs.vh
`ifndef SIPO_DEFS_VH
`define SIPO_DEFS_VH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define SIPO_STAGES     8
`define SIPO_STAGE_RST  8'h00
`define SIPO_SYNC_LEN   3
`define SIPO_BUF_DEPTH  2

`endif

// file: hdl/sipo_out_buffer.v
`timescale 1ns/1ns
`include "sipo_defs.vh"

// Two-entry skid buffer: holds two words for a stalled receiver, then drops inReady
module sipo_out_buffer (
  input  wire                      clk,      // System clock
  input  wire                      rst,      // Async reset, active high
  input  wire [`SIPO_STAGES-1:0]   inData,   // Word from the shifter
  input  wire                      inValid,  // Word offered
  output wire                      inReady,  // Room for a word
  output reg  [`SIPO_STAGES-1:0]   outData,  // Head word
  output wire                      outValid, // Head word valid
  input  wire                      outReady  // Receiver takes head
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [`SIPO_STAGES-1:0] spare;
  reg [1:0]              count;

  wire take = inValid && inReady;
  wire give = outValid && outReady;

  assign inReady  = (count != 2'h2);
  assign outValid = (count != 2'h0);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      outData <= `SIPO_STAGE_RST;
      spare   <= `SIPO_STAGE_RST;
      count   <= 2'h0;
    end else begin
      case ({take, give})
        2'b10: begin
          if (count == 2'h0) begin
            outData <= inData;
          end else begin
            spare <= inData;
          end
          count <= count + 2'h1;
        end
        2'b01: begin
          outData <= spare;
          count   <= count - 2'h1;
        end
        2'b11: begin
          // Count stays at one; the new word replaces the head
          if (count == 2'h1) begin
            outData <= inData;
          end else begin
            outData <= spare;
            spare   <= inData;
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule // sipo_out_buffer

// file: hdl/sipo_shifter.v
`timescale 1ns/1ns
`include "sipo_defs.vh"

module sipo_shifter (
  input  wire                    clk,          // System clock, 20 MHz
  input  wire                    rst,          // Async reset, active high
  input  wire                    shiftClock,   // Shift clock pin, asynchronous
  input  wire                    clearN,       // Clear pin, active low
  input  wire                    serialA,      // Serial data input A
  input  wire                    serialB,      // Serial data input B
  output reg  [`SIPO_STAGES-1:0] stageOutputs, // Stage values, first at bit 0
  output wire [`SIPO_STAGES-1:0] wordData,     // Snapshot after each shift
  output wire                    wordValid,    // Snapshot available
  input  wire                    wordReady     // Receiver takes snapshot
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pins cross into clk; a change counts once flops 2 and 3 agree
  localparam PIN_CLK = 0;
  localparam PIN_A   = 1;
  localparam PIN_B   = 2;
  localparam PINS    = 3;

  wire [PINS-1:0] pinRaw;
  wire [PINS-1:0] pinLevel;

  assign pinRaw[PIN_CLK] = shiftClock;
  assign pinRaw[PIN_A]   = serialA;
  assign pinRaw[PIN_B]   = serialB;

  genvar p;

  generate
    for (p = 0; p < PINS; p = p + 1) begin : gPin
      // First flop may be metastable; only the shift reads it
      reg [`SIPO_SYNC_LEN-1:0] chain;
      reg                      level;

      always @(posedge clk or posedge rst) begin
        if (rst) begin
          chain <= 3'h0;
        end else begin
          chain <= {chain[1:0], pinRaw[p]};
        end
      end

      // Filter: a single-cycle glitch never reaches the level
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          level <= 1'b0;
        end else if (chain[1] == chain[2]) begin
          level <= chain[2];
        end
      end

      assign pinLevel[p] = level;
    end
  endgenerate

  // ----------------------------------------
  // Edge detect and data capture
  // ----------------------------------------
  wire clkLevel = pinLevel[PIN_CLK];
  wire aLevel   = pinLevel[PIN_A];
  wire bLevel   = pinLevel[PIN_B];

  reg  clkPrev;
  reg  aPrev;
  reg  bPrev;

  // Data lags one cycle so the values from before the edge are used
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clkPrev <= 1'b0;
      aPrev   <= 1'b0;
      bPrev   <= 1'b0;
    end else begin
      clkPrev <= clkLevel;
      aPrev   <= aLevel;
      bPrev   <= bLevel;
    end
  end

  wire shiftEdge = clkLevel && !clkPrev;

  // ----------------------------------------
  // Clear
  // ----------------------------------------
  // Clear acts without the clock, so it is a second async reset here
  wire clearAll = rst || !clearN;

  // ----------------------------------------
  // Shift stages
  // ----------------------------------------
  localparam [`SIPO_STAGES-1:0] STAGE_RST = `SIPO_STAGE_RST;

  // Either input gates the other
  wire gatedBit = aPrev & bPrev;
  // Relies on the driver tying an unused input high
  wire dataIn = gatedBit;

  wire [`SIPO_STAGES-1:0] stageNext;

  assign stageNext[0] = dataIn;

  genvar s;

  generate
    for (s = 0; s < `SIPO_STAGES; s = s + 1) begin : gStage
      if (s > 0) begin : gLink
        assign stageNext[s] = stageOutputs[s-1];
      end

      always @(posedge clk or posedge clearAll) begin
        if (clearAll) begin
          stageOutputs[s] <= STAGE_RST[s];
        end else if (shiftEdge) begin
          stageOutputs[s] <= stageNext[s];
        end else begin
          stageOutputs[s] <= stageOutputs[s];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Snapshot path
  // ----------------------------------------
  // Offer one word per shift; a full buffer drops it, pins cannot stall
  reg bufferOffer;
  reg next_bufferOffer;

  always @* begin
    next_bufferOffer = 1'b0;
    if (shiftEdge) begin
      next_bufferOffer = 1'b1;
    end
  end

  // Offer lands one cycle after the shift, when the stages have settled
  always @(posedge clk or posedge clearAll) begin
    if (clearAll) begin
      bufferOffer <= 1'b0;
    end else begin
      bufferOffer <= next_bufferOffer;
    end
  end

  wire bufferReady;

  sipo_out_buffer uBuffer (
    .clk      (clk),
    .rst      (rst),
    .inData   (stageOutputs),
    .inValid  (bufferOffer),
    .inReady  (bufferReady),
    .outData  (wordData),
    .outValid (wordValid),
    .outReady (wordReady)
  );

endmodule // sipo_shifter
